// >>> include/fpec_defs.svh
// Purpose: offsets, field positions, reset values and flash geometry for the flash control block
// Assumes: byte-wide registers on a plain strobe port
// Notes:   definitions only
`ifndef FPEC_DEFS_SVH
`define FPEC_DEFS_SVH

`define FPEC_ADDR_W          3
`define FPEC_OFS_MODE        3'h0
`define FPEC_OFS_STATUS      3'h1
`define FPEC_OFS_IRQ_STAT    3'h2
`define FPEC_OFS_IRQ_MASK    3'h3
`define FPEC_OFS_PROG_ADDR   3'h4
`define FPEC_OFS_ERASE_SEL   3'h5

`define FPEC_BIT_PROG        0
`define FPEC_BIT_ERASE       1
`define FPEC_BIT_VERIFY      2
`define FPEC_BIT_PSETUP      3
`define FPEC_BIT_ESETUP      4
`define FPEC_BIT_SWE         5
`define FPEC_BIT_ERRFLAG     7

`define FPEC_MODE_RST        8'h00
`define FPEC_STATUS_RST      8'h00
`define FPEC_MASK_RST        8'h00

`define FPEC_ADDR_BITS       15
`define FPEC_UNIT_LOW_MASK   8'h7F
`define FPEC_SMALL_BLOCKS    4
`define FPEC_SMALL_BLOCK_SZ  15'h0400
`define FPEC_LARGE_BLOCK_SZ  15'h7000
`define FPEC_LARGE_BASE      15'h1000

`define FPEC_IRQ_DONE        0
`define FPEC_IRQ_ERR         1

`endif

// >>> include/fpec_pkg.sv
// Purpose: shared types for the flash control block
// Assumes: nothing
// Notes:   constants live in fpec_defs.svh
package fpec_pkg;
    typedef enum logic [1:0] {
        FPEC_IDLE,
        FPEC_PROG,
        FPEC_ERASE,
        FPEC_PROTECT
    } fpec_state_type;

    typedef struct packed {
        logic        prog_en;
        logic        erase_en;
        logic        verify_en;
        logic [14:0] addr;
        logic [2:0]  block;
    } fpec_array_cmd_type;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } fpec_reg_req_type;
endpackage

// >>> src/fpec_ctrl.sv
// Purpose: program/erase/verify mode control and error status for a 32-kbyte flash array
// Assumes: 10 MHz clock, synchronous active-low reset, error pulse from the array on the same clock
//
// Decided for this implementation: the address map and strobed register access.
`include "fpec_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module fpec_ctrl (
    input  wire logic                       clock,
    input  wire logic                       nrst,
    input  wire fpec_pkg::fpec_reg_req_type reg_req,
    output logic [7:0]                      reg_rdata,
    input  wire logic                       array_error,
    output fpec_pkg::fpec_array_cmd_type    array_cmd,
    output logic                            irq
);
    logic [7:0]                  mode_r;
    logic [7:0]                  mode_nxt;
    logic                        err_r;
    logic [1:0]                  irq_stat_r;
    logic [1:0]                  irq_mask_r;
    logic [14:0]                 prog_addr_r;
    logic [2:0]                  erase_sel_r;
    logic [7:0]                  rdata_r;
    fpec_pkg::fpec_state_type    state_r;
    fpec_pkg::fpec_state_type    state_nxt;
    fpec_pkg::fpec_array_cmd_type cmd_r;
    logic                        wr_mode;
    logic                        rd_irq;
    logic                        op_done;
    logic                        op_err;

    // block index for an address: 0..3 small, 4 the large block
    function automatic logic [2:0] block_of(input logic [14:0] a);
        if (a >= `FPEC_LARGE_BASE) begin
            return 3'h4;
        end
        return {1'b0, a[11:10]};
    endfunction

    // a program unit must start on a 128-byte boundary
    function automatic logic unit_ok(input logic [14:0] a);
        return (a[7:0] & `FPEC_UNIT_LOW_MASK) == 8'h00;
    endfunction

    assign wr_mode = reg_req.wr && reg_req.addr == `FPEC_OFS_MODE;
    assign rd_irq  = reg_req.rd && reg_req.addr == `FPEC_OFS_IRQ_STAT;

    // mode register; status register has no write path at all
    always_comb begin
        mode_nxt = mode_r;
        if (wr_mode) begin
            mode_nxt = reg_req.wdata & 8'h3F;
        end
        if (err_r || array_error) begin
            mode_nxt = `FPEC_MODE_RST;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            mode_r <= `FPEC_MODE_RST;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // an erase or program error only counts while an operation is active
    assign op_err = array_error && (state_r == fpec_pkg::FPEC_PROG ||
                                    state_r == fpec_pkg::FPEC_ERASE);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            err_r <= 1'b0;
        end else if (op_err) begin
            err_r <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            prog_addr_r <= 15'h0000;
            erase_sel_r <= 3'h0;
        end else if (reg_req.wr && reg_req.addr == `FPEC_OFS_PROG_ADDR) begin
            // unit number in 128-byte steps keeps the start aligned
            prog_addr_r <= {reg_req.wdata, 7'h00};
        end else if (reg_req.wr && reg_req.addr == `FPEC_OFS_ERASE_SEL) begin
            erase_sel_r <= (reg_req.wdata[2:0] > 3'h4) ? 3'h4 : reg_req.wdata[2:0];
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            fpec_pkg::FPEC_IDLE: begin
                if (mode_r[`FPEC_BIT_SWE] && mode_r[`FPEC_BIT_PSETUP] &&
                    mode_r[`FPEC_BIT_PROG]) begin
                    state_nxt = fpec_pkg::FPEC_PROG;
                end else if (mode_r[`FPEC_BIT_SWE] && mode_r[`FPEC_BIT_ESETUP] &&
                             mode_r[`FPEC_BIT_ERASE]) begin
                    state_nxt = fpec_pkg::FPEC_ERASE;
                end
            end
            fpec_pkg::FPEC_PROG: begin
                if (!mode_r[`FPEC_BIT_PROG] || !mode_r[`FPEC_BIT_SWE] ||
                    !mode_r[`FPEC_BIT_PSETUP]) begin
                    state_nxt = fpec_pkg::FPEC_IDLE;
                end
            end
            fpec_pkg::FPEC_ERASE: begin
                if (!mode_r[`FPEC_BIT_ERASE] || !mode_r[`FPEC_BIT_SWE] ||
                    !mode_r[`FPEC_BIT_ESETUP]) begin
                    state_nxt = fpec_pkg::FPEC_IDLE;
                end
            end
            fpec_pkg::FPEC_PROTECT: begin
                state_nxt = fpec_pkg::FPEC_PROTECT;
            end
        endcase
        if (err_r || op_err) begin
            state_nxt = fpec_pkg::FPEC_PROTECT;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_r <= fpec_pkg::FPEC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign op_done = (state_r == fpec_pkg::FPEC_PROG || state_r == fpec_pkg::FPEC_ERASE) &&
                     state_nxt == fpec_pkg::FPEC_IDLE;

    // array drive comes from flops so the pins never glitch
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cmd_r <= '0;
        end else begin
            cmd_r.prog_en   <= state_nxt == fpec_pkg::FPEC_PROG;
            cmd_r.erase_en  <= state_nxt == fpec_pkg::FPEC_ERASE;
            cmd_r.verify_en <= mode_nxt[`FPEC_BIT_VERIFY] &&
                               state_nxt != fpec_pkg::FPEC_PROTECT;
            cmd_r.addr      <= prog_addr_r;
            cmd_r.block     <= erase_sel_r;
        end
    end

    assign array_cmd = cmd_r;

    // sticky events; a new event in the read cycle survives the clear
    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq_stat_r <= 2'h0;
            irq_mask_r <= 2'(`FPEC_MASK_RST);
        end else begin
            irq_stat_r <= (rd_irq ? 2'h0 : irq_stat_r) | {op_err, op_done};
            if (reg_req.wr && reg_req.addr == `FPEC_OFS_IRQ_MASK) begin
                irq_mask_r <= reg_req.wdata[1:0];
            end
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rdata_r <= 8'h00;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                `FPEC_OFS_MODE:      rdata_r <= mode_r;
                `FPEC_OFS_STATUS:    rdata_r <= {err_r, 7'h00};
                `FPEC_OFS_IRQ_STAT:  rdata_r <= {6'h00, irq_stat_r};
                `FPEC_OFS_IRQ_MASK:  rdata_r <= {6'h00, irq_mask_r};
                `FPEC_OFS_PROG_ADDR: rdata_r <= prog_addr_r[14:7];
                `FPEC_OFS_ERASE_SEL: rdata_r <= {5'h00, erase_sel_r};
                default:             rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = rdata_r;

    logic unused_blk;
    assign unused_blk = ^block_of(prog_addr_r);

    a_err_sticky: assert property (@(posedge clock) disable iff (!nrst)
        err_r |=> err_r) else $error("error flag dropped");
    a_err_sets: assert property (@(posedge clock) disable iff (!nrst)
        op_err |=> err_r) else $error("error not flagged");
    a_protect_hold: assert property (@(posedge clock) disable iff (!nrst)
        err_r |-> ##1 (state_r == fpec_pkg::FPEC_PROTECT) [*3])
        else $error("left protection");
    a_protect_clear: assert property (@(posedge clock) disable iff (!nrst)
        err_r |=> mode_r == 8'h00 && !cmd_r.prog_en && !cmd_r.erase_en)
        else $error("mode kept in protection");
    a_status_resv: assert property (@(posedge clock) disable iff (!nrst)
        $past(reg_req.rd) && $past(reg_req.addr) == `FPEC_OFS_STATUS |->
        reg_rdata[6:0] == 7'h00) else $error("reserved bits nonzero");
    a_prog_gate: assert property (@(posedge clock) disable iff (!nrst)
        $rose(state_r == fpec_pkg::FPEC_PROG) |->
        $past(mode_r[`FPEC_BIT_SWE] && mode_r[`FPEC_BIT_PSETUP]))
        else $error("program without gate");
    a_erase_gate: assert property (@(posedge clock) disable iff (!nrst)
        $rose(state_r == fpec_pkg::FPEC_ERASE) |->
        $past(mode_r[`FPEC_BIT_SWE] && mode_r[`FPEC_BIT_ESETUP]))
        else $error("erase without gate");
    a_verify_follow: assert property (@(posedge clock) disable iff (!nrst)
        wr_mode && !err_r && !array_error |=> ##1
        cmd_r.verify_en == $past(reg_req.wdata[`FPEC_BIT_VERIFY], 2))
        else $error("verify not following");
    a_unit_align: assert property (@(posedge clock) disable iff (!nrst)
        cmd_r.addr[6:0] == 7'h00) else $error("unit misaligned");
    a_block_range: assert property (@(posedge clock) disable iff (!nrst)
        cmd_r.block <= 3'h4) else $error("bad erase block");

    // reset is checked without the disable so the reset branch itself is covered
    a_mode_reset: assert property (@(posedge clock)
        !nrst |=> mode_r == 8'h00 && state_r == fpec_pkg::FPEC_IDLE)
        else $error("mode not reset");

    a_prog_entry: assert property (@(posedge clock) disable iff (!nrst)
        state_r == fpec_pkg::FPEC_IDLE && !err_r && mode_r[`FPEC_BIT_SWE] &&
        mode_r[`FPEC_BIT_PSETUP] && mode_r[`FPEC_BIT_PROG] |=>
        state_r == fpec_pkg::FPEC_PROG) else $error("program not entered");

    // program wins over erase when both are requested from idle
    a_erase_entry: assert property (@(posedge clock) disable iff (!nrst)
        state_r == fpec_pkg::FPEC_IDLE && !err_r && mode_r[`FPEC_BIT_SWE] &&
        mode_r[`FPEC_BIT_ESETUP] && mode_r[`FPEC_BIT_ERASE] &&
        !(mode_r[`FPEC_BIT_PSETUP] && mode_r[`FPEC_BIT_PROG]) |=>
        state_r == fpec_pkg::FPEC_ERASE) else $error("erase not entered");

    a_prog_cancel: assert property (@(posedge clock) disable iff (!nrst)
        state_r == fpec_pkg::FPEC_PROG && !mode_r[`FPEC_BIT_PROG] &&
        !err_r && !op_err |=> state_r == fpec_pkg::FPEC_IDLE)
        else $error("program not cancelled");

    a_erase_cancel: assert property (@(posedge clock) disable iff (!nrst)
        state_r == fpec_pkg::FPEC_ERASE && !mode_r[`FPEC_BIT_ERASE] &&
        !err_r && !op_err |=> state_r == fpec_pkg::FPEC_IDLE)
        else $error("erase not cancelled");

    // an array error outside an operation must not lock the part
    a_idle_error: assert property (@(posedge clock) disable iff (!nrst)
        array_error && state_r == fpec_pkg::FPEC_IDLE && !err_r |=> !err_r)
        else $error("idle error flagged");

    a_status_ro: assert property (@(posedge clock) disable iff (!nrst)
        reg_req.wr && reg_req.addr == `FPEC_OFS_STATUS && !op_err |=>
        err_r == $past(err_r)) else $error("status written");

    a_one_op: assert property (@(posedge clock) disable iff (!nrst)
        !(cmd_r.prog_en && cmd_r.erase_en))
        else $error("program and erase together");

    a_protect_idle: assert property (@(posedge clock) disable iff (!nrst)
        state_r == fpec_pkg::FPEC_PROTECT |->
        !cmd_r.prog_en && !cmd_r.erase_en && !cmd_r.verify_en)
        else $error("array driven in protection");

    a_irq_err: assert property (@(posedge clock) disable iff (!nrst)
        op_err |=> irq_stat_r[`FPEC_IRQ_ERR])
        else $error("error event lost");

    a_done_event: assert property (@(posedge clock) disable iff (!nrst)
        op_done |=> irq_stat_r[`FPEC_IRQ_DONE])
        else $error("done event lost");

    a_stat_clear: assert property (@(posedge clock) disable iff (!nrst)
        rd_irq && !op_err && !op_done |=> irq_stat_r == 2'h0)
        else $error("event status not cleared");

    a_rdata_idle: assert property (@(posedge clock) disable iff (!nrst)
        !reg_req.rd |=> reg_rdata == 8'h00)
        else $error("read data outside slot");

    a_mode_upper: assert property (@(posedge clock) disable iff (!nrst)
        mode_r[7:6] == 2'h0) else $error("mode upper bits set");

    a_verify_prot: assert property (@(posedge clock) disable iff (!nrst)
        err_r |-> !cmd_r.verify_en) else $error("verify in protection");

    a_addr_follow: assert property (@(posedge clock) disable iff (!nrst)
        1'b1 |=> cmd_r.addr == $past(prog_addr_r))
        else $error("unit address not passed on");

    a_block_follow: assert property (@(posedge clock) disable iff (!nrst)
        1'b1 |=> cmd_r.block == $past(erase_sel_r))
        else $error("erase block not passed on");

    a_unit_write: assert property (@(posedge clock) disable iff (!nrst)
        reg_req.wr && reg_req.addr == `FPEC_OFS_PROG_ADDR |=> unit_ok(prog_addr_r))
        else $error("unit start misaligned");

    c_prog: cover property (@(posedge clock) disable iff (!nrst)
        state_r == fpec_pkg::FPEC_PROG ##1 state_r == fpec_pkg::FPEC_IDLE);
    c_erase: cover property (@(posedge clock) disable iff (!nrst)
        $rose(state_r == fpec_pkg::FPEC_ERASE));
    c_protect: cover property (@(posedge clock) disable iff (!nrst)
        $rose(state_r == fpec_pkg::FPEC_PROTECT));
    c_irq: cover property (@(posedge clock) disable iff (!nrst) $rose(irq));
    c_verify: cover property (@(posedge clock) disable iff (!nrst)
        $rose(cmd_r.verify_en));
endmodule // fpec_ctrl

`default_nettype wire

// >>> tb/fpec_flash_model.sv
// Purpose: behavioural flash array on the far side of the flash control block
// Assumes: one clock; the bench asks for an error pulse through inject
// Notes:   counts any command that breaks the array geometry
`timescale 1ns/1ps
`default_nettype none

module fpec_flash_model (
    input  wire logic                         clock,
    input  wire logic                         nrst,
    input  wire fpec_pkg::fpec_array_cmd_type array_cmd,
    input  wire logic                         inject,
    output logic                              array_error,
    output logic [7:0]                        n_bad
);
    // one-cycle error pulse, raised only when the bench asks for it
    always_ff @(posedge clock) begin
        if (!nrst) begin
            array_error <= 1'b0;
        end else begin
            array_error <= inject;
        end
    end

    // a unit must start on a 128-byte boundary, and only five erase blocks exist
    always_ff @(posedge clock) begin
        if (!nrst) begin
            n_bad <= 8'h00;
        end else if ((array_cmd.prog_en && array_cmd.addr[6:0] != 7'h00) ||
                     (array_cmd.erase_en && array_cmd.block > 3'h4)) begin
            n_bad <= n_bad + 8'h01;
        end
    end
endmodule // fpec_flash_model

`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the flash control block
// Assumes: 10 MHz clock, synchronous active-low reset, bus driven just after rising edges
// Notes:   expected values come from a small integer model kept in this module
`timescale 1ns/1ps
`default_nettype none
`include "fpec_defs.svh"

module tb_top;
    logic                         clock = 1'b0;
    logic                         nrst = 1'b0;
    fpec_pkg::fpec_reg_req_type   req = '0;
    logic [7:0]                   rdata;
    logic                         array_error;
    logic                         inject = 1'b0;
    fpec_pkg::fpec_array_cmd_type cmd;
    logic                         irq;
    logic [7:0]                   n_bad;
    logic [7:0]                   v;
    logic [7:0]                   got;
    int                           num_errors = 0;
    int                           n_checks = 0;
    int                           exp_mode = 0;
    int                           exp_err = 0;
    int                           exp_st = 0;

    always #50 clock = ~clock;

    fpec_ctrl dut_u (.clock(clock), .nrst(nrst), .reg_req(req), .reg_rdata(rdata),
        .array_error(array_error), .array_cmd(cmd), .irq(irq));
    fpec_flash_model far_u (.clock(clock), .nrst(nrst), .array_cmd(cmd), .inject(inject),
        .array_error(array_error), .n_bad(n_bad));

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, e, g);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req <= '0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req <= '0;
        #1 d = rdata;
    endtask

    task automatic wait2;
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic mode_set(input logic [7:0] d);
        wr(`FPEC_OFS_MODE, d);
        if (exp_err == 0) exp_mode = d & 8'h3F;
    endtask

    task automatic chk_cmd;
        logic pg;
        logic eg;
        // 0 idle, 1 program, 2 erase, 3 protection; a running mode holds while gated
        pg = exp_mode[0] & exp_mode[3] & exp_mode[5];
        eg = exp_mode[1] & exp_mode[4] & exp_mode[5];
        if (exp_err != 0) exp_st = 3;
        if (exp_st == 1 && !pg) exp_st = 0;
        if (exp_st == 2 && !eg) exp_st = 0;
        if (exp_st == 0) exp_st = pg ? 1 : (eg ? 2 : 0);
        wait2;
        chk("prog_en", exp_st == 1, cmd.prog_en);
        chk("erase_en", exp_st == 2, cmd.erase_en);
        chk("verify_en", exp_mode[2] && exp_st != 3, cmd.verify_en);
    endtask

    task automatic pulse_error;
        @(posedge clock);
        inject <= 1'b1;
        @(posedge clock);
        inject <= 1'b0;
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clock);
        num_errors++;
        wrap_up;
    end

    initial begin
        v = $urandom(32'hBECC);
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0], got);
            chk("reset read", 0, got);
        end
        mode_set(8'h21);
        chk_cmd;
        mode_set(8'h29);
        chk_cmd;
        v = $urandom;
        wr(`FPEC_OFS_PROG_ADDR, v);
        wait2;
        chk("unit addr", {v, 7'h00}, cmd.addr);
        mode_set(8'h2C);
        chk_cmd;
        chk("irq masked", 0, irq);
        wr(`FPEC_OFS_IRQ_MASK, 8'h01);
        wait2;
        chk("irq done", 1, irq);
        rd(`FPEC_OFS_IRQ_STAT, got);
        chk("irq stat", 8'h01, got);
        wait2;
        chk("irq cleared", 0, irq);
        mode_set(8'h22);
        chk_cmd;
        mode_set(8'h32);
        chk_cmd;
        for (int i = 0; i < 8; i++) begin
            wr(`FPEC_OFS_ERASE_SEL, i[7:0]);
            wait2;
            chk("erase block", (i > 4) ? 4 : i, cmd.block);
        end
        mode_set(8'h3B);
        chk_cmd;
        mode_set(8'h00);
        chk_cmd;
        rd(`FPEC_OFS_IRQ_STAT, got);
        wr(3'h6, 8'hFF);
        rd(3'h6, got);
        chk("unmapped read", 0, got);
        rd(`FPEC_OFS_STATUS, got);
        chk("status idle", 0, got);
        pulse_error;
        rd(`FPEC_OFS_STATUS, got);
        chk("idle error", 0, got);
        wr(`FPEC_OFS_IRQ_MASK, 8'h03);
        mode_set(8'h29);
        chk_cmd;
        pulse_error;
        exp_err = 1;
        exp_mode = 0;
        chk_cmd;
        rd(`FPEC_OFS_STATUS, got);
        chk("error flag", 8'h80, got);
        chk("irq error", 1, irq);
        mode_set(8'h29);
        chk_cmd;
        rd(`FPEC_OFS_MODE, got);
        chk("mode locked", 0, got);
        rd(`FPEC_OFS_IRQ_STAT, got);
        chk("irq err bit", 8'h02, got & 8'h02);
        wait2;
        chk("irq after read", 0, irq);
        chk("geometry", 0, n_bad);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        exp_err = 0;
        exp_st = 0;
        rd(`FPEC_OFS_STATUS, got);
        chk("flag after reset", 0, got);
        wrap_up;
    end
endmodule // tb_top

`default_nettype wire
